/* modulo_position_range_bench.sv */
// Self-checking bench for the modulo position-range block
`timescale 1ns/1ps
module modulo_position_range_bench;
  import mpr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic pwr = 1'b0;
  logic req = 1'b0;
  logic is_abs = 1'b0;
  logic signed [POS_W-1:0] val = '0;
  logic signed [POS_W-1:0] act = '0;
  logic [ADR_W-1:0] addr;
  logic [POS_W-1:0] wdata;
  logic [POS_W-1:0] rdata;
  logic [POS_W-1:0] rd_seen;
  logic wr;
  logic rd;
  logic refused;
  logic ref_seen;
  logic vld;
  logic neg;
  logic signed [CALC_W-1:0] travel;
  logic signed [POS_W-1:0] end_pos;
  int err_count = 0;
  int n_compared = 0;

  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  mpr_master_model u_master (.clk_i(clk_sys_i), .par_rdata_i(rdata),
    .par_wr_refused_i(refused), .par_addr_o(addr), .par_wr_o(wr),
    .par_wdata_o(wdata), .par_rd_o(rd));

  mpr_modulo_range u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .power_stage_en_i(pwr), .par_addr_i(addr), .par_wr_i(wr),
    .par_wdata_i(wdata), .par_rd_i(rd), .par_rdata_o(rdata),
    .par_wr_refused_o(refused), .move_req_i(req), .move_abs_i(is_abs),
    .move_val_i(val), .actual_pos_i(act), .move_vld_o(vld), .travel_o(travel),
    .end_pos_o(end_pos), .move_neg_o(neg));

  // Compare and count; four-state equality so X never matches
  task automatic chk(input logic [CALC_W-1:0] seen, input logic [CALC_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [ADR_W-1:0] a, input logic [POS_W-1:0] d, input logic r);
    u_master.wr(a, d, ref_seen);
    chk(ref_seen, r);
  endtask : wreg

  task automatic rreg(input logic [ADR_W-1:0] a, input logic [POS_W-1:0] e);
    u_master.rd(a, rd_seen);
    chk(rd_seen, e);
  endtask : rreg

  // One move; result is a pulse one cycle after the request
  task automatic mv(input logic a, input int v, input int ac, input int et, input int ee);
    @(posedge clk_sys_i);
    #1;
    chk(vld, 1'b0);
    req = 1'b1;
    is_abs = a;
    val = v;
    act = ac;
    @(posedge clk_sys_i);
    #1;
    req = 1'b0;
    chk(vld, 1'b1);
    chk(travel, et);
    chk(end_pos, ee);
    chk(neg, et < 0);
  endtask : mv

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // Watchdog far beyond the hundred or so cycles the sequence needs
  initial
  begin
    #20000;
    err_count++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    rreg(ADDR_LOWER_BOUND, 32'h0);
    rreg(ADDR_UPPER_BOUND, 32'hE10);
    rreg(ADDR_DIRECTION_SEL, 32'h0);
    rreg(ADDR_MULTI_RANGE_SEL, 32'h0);
    rreg(ADDR_WRAP_ACTIVATION, 32'h0);
    rreg(16'h0680, 32'h0);
    mv(1, 5000, 700, 4300, 5000);
    mv(0, -3300, 700, -3300, -2600);
    wreg(ADDR_WRAP_ACTIVATION, 32'h1, 1'b0);
    mv(0, 500, 700, 500, 1200);
    mv(0, 3300, 700, 3300, 400);
    mv(0, -500, 700, -500, 200);
    mv(0, -3300, 700, -3300, 1000);
    mv(1, 1500, 700, 800, 1500);
    mv(1, 5000, 700, 700, 1400);
    mv(1, 2500, 700, 1800, 2500);
    mv(1, 2900, 700, -1400, 2900);
    wreg(ADDR_MULTI_RANGE_SEL, 32'h1, 1'b0);
    mv(1, 5000, 700, 4300, 1400);
    wreg(ADDR_DIRECTION_SEL, 32'h1, 1'b0);
    mv(1, 5000, 700, 4300, 1400);
    mv(1, 500, 700, 3400, 500);
    wreg(ADDR_DIRECTION_SEL, 32'h2, 1'b0);
    mv(1, -5000, 700, -5700, 2200);
    mv(1, 1500, 700, -2800, 1500);
    wreg(ADDR_MULTI_RANGE_SEL, 32'h0, 1'b0);
    mv(1, -5000, 700, -2100, 2200);
    wreg(ADDR_DIRECTION_SEL, 32'h1, 1'b0);
    mv(1, 2900, 700, 2200, 2900);
    wreg(ADDR_DIRECTION_SEL, 32'h3, 1'b1);
    wreg(ADDR_MULTI_RANGE_SEL, 32'h2, 1'b1);
    rreg(ADDR_DIRECTION_SEL, 32'h1);
    // Power stage on: bounds and wrap activation locked, direction and multi-range still live
    pwr = 1'b1;
    wreg(ADDR_LOWER_BOUND, 32'h64, 1'b1);
    wreg(ADDR_UPPER_BOUND, 32'h1388, 1'b1);
    rreg(ADDR_LOWER_BOUND, 32'h0);
    rreg(ADDR_UPPER_BOUND, 32'hE10);
    wreg(ADDR_WRAP_ACTIVATION, 32'h0, 1'b1);
    rreg(ADDR_WRAP_ACTIVATION, 32'h1);
    wreg(ADDR_DIRECTION_SEL, 32'h0, 1'b0);
    mv(1, 2900, 700, -1400, 2900);
    // Signed range straddling zero, width 360
    pwr = 1'b0;
    wreg(ADDR_LOWER_BOUND, 32'hFFFFFF9C, 1'b0);
    wreg(ADDR_UPPER_BOUND, 32'h104, 1'b0);
    rreg(ADDR_LOWER_BOUND, 32'hFFFFFF9C);
    rreg(ADDR_UPPER_BOUND, 32'h104);
    mv(0, 100, 300, 100, 40);
    mv(1, 700, 200, 140, -20);
    end_of_test();
  end
endmodule : modulo_position_range_bench

/* mpr_master_model.sv */
// Fieldbus master model that writes and reads drive parameters
`timescale 1ns/1ps
module mpr_master_model
  import mpr_pkg::*;
(
  input wire logic clk_i,
  input wire logic [mpr_pkg::POS_W-1:0] par_rdata_i,
  input wire logic par_wr_refused_i,
  output logic [mpr_pkg::ADR_W-1:0] par_addr_o,
  output logic par_wr_o,
  output logic [mpr_pkg::POS_W-1:0] par_wdata_o,
  output logic par_rd_o
);
  // Idle bus: strobes low, lines parked on a pattern
  initial
  begin
    par_addr_o = 16'hFFFF;
    par_wr_o = 1'b0;
    par_wdata_o = 32'hA5A5A5A5;
    par_rd_o = 1'b0;
  end

  // Callers order bound writes so lower stays below upper, under the ceiling
  task automatic wr(input logic [ADR_W-1:0] a, input logic [POS_W-1:0] d, output logic refused);
    @(posedge clk_i);
    #1;
    par_addr_o = a;
    par_wdata_o = d;
    par_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    par_wr_o = 1'b0;
    par_addr_o = ~a; // Released lines no longer hold the old value
    par_wdata_o = ~d;
    refused = par_wr_refused_i;
  endtask : wr

  // One read, data taken one cycle after the strobe
  task automatic rd(input logic [ADR_W-1:0] a, output logic [POS_W-1:0] d);
    @(posedge clk_i);
    #1;
    par_addr_o = a;
    par_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    par_rd_o = 1'b0;
    par_addr_o = ~a;
    d = par_rdata_i;
  endtask : rd
endmodule : mpr_master_model

/* mpr_math.sv */
// Travel and end-position computation for one move request, registered outputs
`timescale 1ns/1ps
module mpr_math
  import mpr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic abs_i,
  input wire logic signed [mpr_pkg::POS_W-1:0] val_i,
  input wire logic signed [mpr_pkg::POS_W-1:0] act_i,
  input wire logic signed [mpr_pkg::POS_W-1:0] lower_i,
  input wire logic signed [mpr_pkg::POS_W-1:0] upper_i,
  input wire logic [mpr_pkg::SEL_W-1:0] dir_i,
  input wire logic multi_i,
  input wire logic wrap_i,
  output logic vld_o,
  output logic signed [mpr_pkg::CALC_W-1:0] travel_o,
  output logic signed [mpr_pkg::POS_W-1:0] end_pos_o
);
  import mpr_pkg::*;

  // Non-negative remainder; an empty range leaves the value alone
  function automatic logic signed [CALC_W-1:0] posmod(input logic signed [CALC_W-1:0] x,
                                                      input logic signed [CALC_W-1:0] m);
    logic signed [CALC_W-1:0] r;
    r = x;
    if (m > 0)
    begin
      r = x % m;
      if (r < 0)
        r = r + m;
    end
    return r;
  endfunction : posmod

  logic signed [CALC_W-1:0] w;
  logic signed [CALC_W-1:0] lo;
  logic signed [CALC_W-1:0] act;
  logic signed [CALC_W-1:0] val;
  logic signed [CALC_W-1:0] d_pos;
  logic signed [CALC_W-1:0] d_neg;
  logic signed [CALC_W-1:0] d_raw;
  logic signed [CALC_W-1:0] travel_d;
  logic signed [CALC_W-1:0] end_d;

  // Distance choice per mode; wide arithmetic keeps sums of two positions exact
  always_comb
  begin
    lo = CALC_W'(lower_i);
    act = CALC_W'(act_i);
    val = CALC_W'(val_i);
    w = CALC_W'(upper_i) - lo;
    d_raw = val - act;
    d_pos = posmod(d_raw, w);
    d_neg = (d_pos == '0) ? '0 : d_pos - w;
    travel_d = abs_i ? d_raw : val;
    if (!wrap_i)
      end_d = act + travel_d;
    else
    begin
      if (abs_i)
      begin
        case (dir_i)
          DIR_POSITIVE: travel_d = (multi_i && d_raw >= 0) ? d_raw : d_pos;
          DIR_NEGATIVE: travel_d = (multi_i && d_raw <= 0) ? d_raw : d_neg;
          default:
          begin
            // Tie goes positive: the compare is less-or-equal
            if (multi_i)
              travel_d = d_raw;
            else if (d_pos <= w - d_pos)
              travel_d = d_pos;
            else
              travel_d = d_neg;
          end
        endcase
      end
      end_d = lo + posmod(act + travel_d - lo, w);
    end
  end

  // Result registers, one cycle after the request
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      vld_o <= 1'b0;
      travel_o <= '0;
      end_pos_o <= '0;
    end
    else
    begin
      vld_o <= req_i;
      if (req_i)
      begin
        travel_o <= travel_d;
        end_pos_o <= end_d[POS_W-1:0];
      end
    end
  end

endmodule : mpr_math

/* mpr_modulo_range.sv */
// Modulo position-range block: parameter store and move mapping
//
// Operation
// - Bound writes refused while power stage enabled
// - New parameter values act immediately
// - Lower bound signed 32-bit, default zero
// - Upper bound signed 32-bit, default 3600
// - Direction: 0 shortest, 1 positive, 2 negative
// - Shortest mode picks nearer travel direction in single range
// - Equal distances move positive
// - Multi-range: 0 single range, 1 several
// - Wrap only when wrap activation is 1
// - Multi-range targets span consecutive ranges
`timescale 1ns/1ps
module mpr_modulo_range
  import mpr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic power_stage_en_i,
  input wire logic [mpr_pkg::ADR_W-1:0] par_addr_i,
  input wire logic par_wr_i,
  input wire logic [mpr_pkg::POS_W-1:0] par_wdata_i,
  input wire logic par_rd_i,
  output logic [mpr_pkg::POS_W-1:0] par_rdata_o,
  output logic par_wr_refused_o,
  input wire logic move_req_i,
  input wire logic move_abs_i,
  input wire logic signed [mpr_pkg::POS_W-1:0] move_val_i,
  input wire logic signed [mpr_pkg::POS_W-1:0] actual_pos_i,
  output logic move_vld_o,
  output logic signed [mpr_pkg::CALC_W-1:0] travel_o,
  output logic signed [mpr_pkg::POS_W-1:0] end_pos_o,
  output logic move_neg_o
);
  import mpr_pkg::*;

  logic signed [POS_W-1:0] lower_q;
  logic signed [POS_W-1:0] upper_q;
  logic [SEL_W-1:0] dir_q;
  logic [SEL_W-1:0] multi_q;
  logic [SEL_W-1:0] wrap_q;
  logic wr_lower;
  logic wr_upper;
  logic wr_dir;
  logic wr_multi;
  logic wr_wrap;
  logic locked_hit;
  logic range_bad;

  // Address decode
  assign wr_lower = par_wr_i && (par_addr_i == ADDR_LOWER_BOUND);
  assign wr_upper = par_wr_i && (par_addr_i == ADDR_UPPER_BOUND);
  assign wr_dir = par_wr_i && (par_addr_i == ADDR_DIRECTION_SEL);
  assign wr_multi = par_wr_i && (par_addr_i == ADDR_MULTI_RANGE_SEL);
  assign wr_wrap = par_wr_i && (par_addr_i == ADDR_WRAP_ACTIVATION);

  // Bounds and activation lock while the power stage is live
  assign locked_hit = (wr_lower || wr_upper || wr_wrap) && power_stage_en_i;
  // Selector codes outside the decoded set are refused
  assign range_bad = (wr_dir && par_wdata_i > POS_W'(DIR_NEGATIVE))
                  || (wr_multi && par_wdata_i > POS_W'(SEL_ON))
                  || (wr_wrap && par_wdata_i > POS_W'(SEL_ON));

  // Modulo bounds, signed user units
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      lower_q <= RST_LOWER_BOUND;
      upper_q <= RST_UPPER_BOUND;
    end
    else if (!power_stage_en_i)
    begin
      if (wr_lower)
        lower_q <= par_wdata_i;
      if (wr_upper)
        upper_q <= par_wdata_i;
    end
  end

  // Selectors; direction and multi-range may change while moving
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      dir_q <= RST_DIRECTION_SEL;
      multi_q <= RST_MULTI_RANGE_SEL;
      wrap_q <= RST_WRAP_ACTIVATION;
    end
    else
    begin
      if (wr_dir && !range_bad)
        dir_q <= par_wdata_i[SEL_W-1:0];
      if (wr_multi && !range_bad)
        multi_q <= par_wdata_i[SEL_W-1:0];
      if (wr_wrap && !range_bad && !power_stage_en_i)
        wrap_q <= par_wdata_i[SEL_W-1:0];
    end
  end

  // Refusal pulse, one cycle after the rejected write
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      par_wr_refused_o <= 1'b0;
    else
      par_wr_refused_o <= locked_hit || range_bad;
  end

  // Read-back; unmapped addresses read zero
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      par_rdata_o <= '0;
    else if (par_rd_i)
    begin
      case (par_addr_i)
        ADDR_LOWER_BOUND: par_rdata_o <= lower_q;
        ADDR_UPPER_BOUND: par_rdata_o <= upper_q;
        ADDR_DIRECTION_SEL: par_rdata_o <= {{(POS_W-SEL_W){1'b0}}, dir_q};
        ADDR_MULTI_RANGE_SEL: par_rdata_o <= {{(POS_W-SEL_W){1'b0}}, multi_q};
        ADDR_WRAP_ACTIVATION: par_rdata_o <= {{(POS_W-SEL_W){1'b0}}, wrap_q};
        default: par_rdata_o <= '0;
      endcase
    end
  end

  // Live parameters feed the computation, no re-enable needed
  mpr_math u_math (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .req_i(move_req_i),
    .abs_i(move_abs_i),
    .val_i(move_val_i),
    .act_i(actual_pos_i),
    .lower_i(lower_q),
    .upper_i(upper_q),
    .dir_i(dir_q),
    .multi_i(multi_q == SEL_ON),
    .wrap_i(wrap_q == SEL_ON),
    .vld_o(move_vld_o),
    .travel_o(travel_o),
    .end_pos_o(end_pos_o)
  );

  assign move_neg_o = travel_o < 0;

  // Helper: range width as seen by the request
  logic signed [CALC_W-1:0] width_c;
  assign width_c = CALC_W'(upper_q) - CALC_W'(lower_q);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  sequence s_locked_bound_write;
    (wr_lower || wr_upper) && power_stage_en_i;
  endsequence
  sequence s_bounds_unchanged;
    lower_q == $past(lower_q) && upper_q == $past(upper_q) && par_wr_refused_o;
  endsequence

  property p_bound_lock;
    s_locked_bound_write |=> s_bounds_unchanged;
  endproperty
  a_bound_lock: assert property (p_bound_lock) else $error("bound changed while locked");

  property p_bound_write;
    wr_lower && !power_stage_en_i |=> lower_q == $past(par_wdata_i) && !par_wr_refused_o;
  endproperty
  a_bound_write: assert property (p_bound_write) else $error("lower bound write lost");

  property p_defaults;
    $fell(srst_i) |-> lower_q == RST_LOWER_BOUND && upper_q == RST_UPPER_BOUND
      && dir_q == RST_DIRECTION_SEL && multi_q == RST_MULTI_RANGE_SEL
      && wrap_q == RST_WRAP_ACTIVATION;
  endproperty
  a_defaults: assert property (p_defaults) else $error("wrong factory default");

  property p_dir_decode;
    wr_dir && par_wdata_i > POS_W'(DIR_NEGATIVE) |=> dir_q == $past(dir_q) ##0 par_wr_refused_o;
  endproperty
  a_dir_decode: assert property (p_dir_decode) else $error("bad direction code taken");

  // Accepted direction must be live on the very next edge, power stage state regardless
  property p_immediate;
    wr_dir && !range_bad
      |=> (dir_q == $past(par_wdata_i[SEL_W-1:0]) && !par_wr_refused_o)
      and (move_req_i |=> move_vld_o);
  endproperty
  a_immediate: assert property (p_immediate) else $error("direction write not applied");

  property p_pos_only;
    move_req_i && move_abs_i && wrap_q == SEL_ON && dir_q == DIR_POSITIVE |=> travel_o >= 0;
  endproperty
  a_pos_only: assert property (p_pos_only) else $error("positive mode moved back");

  property p_neg_only;
    move_req_i && move_abs_i && wrap_q == SEL_ON && dir_q == DIR_NEGATIVE |=> travel_o <= 0;
  endproperty
  a_neg_only: assert property (p_neg_only) else $error("negative mode moved forward");

  property p_shortest;
    move_req_i && move_abs_i && wrap_q == SEL_ON && dir_q == DIR_SHORTEST
      && multi_q == SEL_OFF && width_c > 0
      |=> (travel_o >= 0) ? (2 * travel_o <= $past(width_c)) : (-2 * travel_o < $past(width_c));
  endproperty
  a_shortest: assert property (p_shortest) else $error("not the shortest travel");

  property p_wrap_range;
    move_req_i && wrap_q == SEL_ON && width_c > 0
      |=> end_pos_o >= $past(lower_q) && end_pos_o < $past(upper_q);
  endproperty
  a_wrap_range: assert property (p_wrap_range) else $error("end outside modulo range");

  property p_no_wrap;
    move_req_i && !move_abs_i && wrap_q == SEL_OFF
      |=> end_pos_o == POS_W'($past(actual_pos_i) + $past(move_val_i));
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("wrapped while inactive");

  property p_multi_short;
    move_req_i && move_abs_i && wrap_q == SEL_ON && dir_q == DIR_SHORTEST && multi_q == SEL_ON
      |=> travel_o == CALC_W'($past(move_val_i)) - CALC_W'($past(actual_pos_i));
  endproperty
  a_multi_short: assert property (p_multi_short) else $error("multi-range travel wrong");

  property p_readback;
    par_rd_i && par_addr_i == ADDR_UPPER_BOUND |=> par_rdata_o == $past(upper_q);
  endproperty
  a_readback: assert property (p_readback) else $error("upper bound read-back wrong");

endmodule : mpr_modulo_range

/* mpr_pkg.sv */
// Package for the modulo position-range block: parameter addresses, defaults, encodings
package mpr_pkg;

  // Widths of positions, parameter addresses and internal arithmetic
  localparam int unsigned POS_W = 32;
  localparam int unsigned SEL_W = 16;
  localparam int unsigned ADR_W = 16;
  localparam int unsigned CALC_W = 34;

  // Parameter addresses
  localparam logic [ADR_W-1:0] ADDR_WRAP_ACTIVATION = 16'h0670;
  localparam logic [ADR_W-1:0] ADDR_LOWER_BOUND = 16'h0672;
  localparam logic [ADR_W-1:0] ADDR_UPPER_BOUND = 16'h0674;
  localparam logic [ADR_W-1:0] ADDR_DIRECTION_SEL = 16'h0676;
  localparam logic [ADR_W-1:0] ADDR_MULTI_RANGE_SEL = 16'h0678;

  // Factory defaults
  localparam logic [POS_W-1:0] RST_LOWER_BOUND = 32'h00000000;
  localparam logic [POS_W-1:0] RST_UPPER_BOUND = 32'h00000E10;
  localparam logic [SEL_W-1:0] RST_DIRECTION_SEL = 16'h0000;
  localparam logic [SEL_W-1:0] RST_MULTI_RANGE_SEL = 16'h0000;
  localparam logic [SEL_W-1:0] RST_WRAP_ACTIVATION = 16'h0000;

  // Direction selector codes and on/off selector codes
  localparam logic [SEL_W-1:0] DIR_SHORTEST = 16'h0000;
  localparam logic [SEL_W-1:0] DIR_POSITIVE = 16'h0001;
  localparam logic [SEL_W-1:0] DIR_NEGATIVE = 16'h0002;
  localparam logic [SEL_W-1:0] SEL_OFF = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_ON = 16'h0001;

endpackage : mpr_pkg
